// ### inc/lcb_pkg.sv
// constants, encodings and carrier types for the logic/compare/bcd datapath
package lcb_pkg;

   // opcode encodings; register forms match on the top five bits,
   // pointer forms on the top seven bits
   localparam logic [7:0] OPC_AND_A_IMM  = 8'h54;
   localparam logic [7:0] OPC_AND_A_DIR  = 8'h55;
   localparam logic [7:0] OPC_AND_A_IND  = 8'h56;
   localparam logic [7:0] OPC_AND_A_REG  = 8'h58;
   localparam logic [7:0] OPC_AND_DIR_A  = 8'h52;
   localparam logic [7:0] OPC_AND_DIR_IM = 8'h53;
   localparam logic [7:0] OPC_AND_C_BIT  = 8'h82;
   localparam logic [7:0] OPC_AND_C_NBIT = 8'hB0;
   localparam logic [7:0] OPC_CMP_A_IMM  = 8'hB4;
   localparam logic [7:0] OPC_CMP_A_DIR  = 8'hB5;
   localparam logic [7:0] OPC_CMP_IND    = 8'hB6;
   localparam logic [7:0] OPC_CMP_REG    = 8'hB8;
   localparam logic [7:0] OPC_CLEAR_A    = 8'hE4;
   localparam logic [7:0] OPC_CLEAR_C    = 8'hC3;
   localparam logic [7:0] OPC_CLEAR_BIT  = 8'hC2;
   localparam logic [7:0] OPC_COMPL_A    = 8'hF4;
   localparam logic [7:0] OPC_COMPL_C    = 8'hB3;
   localparam logic [7:0] OPC_COMPL_BIT  = 8'hB2;
   localparam logic [7:0] OPC_DEC_ADJ    = 8'hD4;
   localparam logic [7:0] REG_FORM_MASK  = 8'hF8;
   localparam logic [7:0] IND_FORM_MASK  = 8'hFE;

   // special function register addresses and the bit-addressable area base in data memory
   localparam logic [7:0] SFR_PORT       = 8'h90;
   localparam logic [7:0] SFR_STATUS     = 8'hD0;
   localparam logic [7:0] SFR_ACC        = 8'hE0;
   localparam logic [7:0] BIT_AREA_BASE  = 8'h20;

   // status word bit positions
   localparam int FLAG_CARRY     = 7;
   localparam int FLAG_AUX_CARRY = 6;
   localparam int FLAG_BANK_HI   = 4;
   localparam int FLAG_BANK_LO   = 3;
   localparam int FLAG_OVERFLOW  = 2;
   localparam int FLAG_PARITY    = 0;

   // reset values
   localparam logic [7:0]  ACC_RST    = 8'h00;
   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [7:0]  PORT_RST   = 8'hFF;
   localparam logic [15:0] PC_RST     = 16'h0000;

   // instruction length and machine cycle counts
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [2:0] CYC_1 = 3'h1;
   localparam logic [2:0] CYC_2 = 3'h2;

   // decimal adjust constants
   localparam logic [8:0] ADJ_LOW  = 9'h006;
   localparam logic [8:0] ADJ_HIGH = 9'h060;
   localparam logic [3:0] BCD_MAX  = 4'h9;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_PTR  = 3'h2,
      ST_EXEC = 3'h4
   } lcb_state_t;

   typedef enum logic [3:0] {
      OP_ILLEGAL, OP_AND_A, OP_AND_DIR, OP_AND_C, OP_AND_CN, OP_CMP_JUMP,
      OP_CLEAR_A, OP_CLEAR_C, OP_CLEAR_BIT, OP_COMPL_A, OP_COMPL_C,
      OP_COMPL_BIT, OP_DEC_ADJ
   } lcb_op_t;

   typedef enum logic [2:0] {
      AM_NONE, AM_IMM, AM_REG, AM_DIR, AM_IND, AM_BIT
   } lcb_amode_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } lcb_instr_t;

   typedef struct packed {
      lcb_op_t    op;
      lcb_amode_t amode;
      logic [1:0] bytes;
      logic [2:0] cycles;
   } lcb_dec_t;

   typedef struct packed {
      logic       illegal;
      logic [1:0] bytes;
      logic [2:0] cycles;
      logic       branch;
   } lcb_retire_t;

endpackage

// ### rtl/lcb_ram.sv
// internal data memory, 256 bytes, registered read port
module lcb_ram (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [7:0] rd_addr_i,
   input  wire logic       wr_en_i,
   input  wire logic [7:0] wr_addr_i,
   input  wire logic [7:0] wr_data_i,
   output logic      [7:0] rd_data_o
);

   logic [7:0] mem_q [256];
   logic [7:0] rd_data_q;

   // contents are not reset; software initialises its own data
   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // read data always comes out of a flop
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= mem_q[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_q;

endmodule

// ### rtl/lcb_dec_adj.sv
// decimal adjust of the accumulator after a bcd addition
module lcb_dec_adj (
   input  wire logic [7:0] acc_i,
   input  wire logic       carry_i,
   input  wire logic       aux_carry_i,
   output logic      [7:0] acc_o,
   output logic            carry_o
);

   logic [8:0] low_sum;
   logic       carry_mid;
   logic [8:0] high_sum;

   // both steps are one combinational path, so the whole adjust fits one
   // cycle; the net effect is adding 00, 06, 60 or 66
   always_comb begin
      low_sum = {1'b0, acc_i};
      if (acc_i[3:0] > lcb_pkg::BCD_MAX || aux_carry_i) begin
         low_sum = {1'b0, acc_i} + lcb_pkg::ADJ_LOW;
      end
      carry_mid = carry_i | low_sum[8];
      high_sum  = {1'b0, low_sum[7:0]};
      if (carry_mid || low_sum[7:4] > lcb_pkg::BCD_MAX) begin
         high_sum = {1'b0, low_sum[7:0]} + lcb_pkg::ADJ_HIGH;
      end
      acc_o   = high_sum[7:0];
      carry_o = carry_mid | high_sum[8];
   end

endmodule

// ### rtl/lcb_core.sv
// logic, compare-jump, clear/complement and decimal adjust datapath
//
// Overview of operation
// - byte AND stores result, flags untouched
// - port read-modify-write uses output latch value
// - AND immediate into A: two bytes, one cycle
// - AND A into direct: writes back direct
// - bit zero clears carry, else carry kept
// - carry AND bit: two bytes, two cycles
// - inverted variant uses complement, source unchanged
// - compare jump: pc plus three, then rel
// - carry set when first below second
// - exactly four compare operand pairings
// - register and pointer compare forms encoded
// - clear accumulator to zero, no flags
// - clear carry or direct bit
// - complement accumulator in one cycle
// - complement carry or direct bit
// - adjust low nibble, carry only set
// - adjust high nibble, overflow untouched
// - whole decimal adjust in one cycle
module lcb_core (
   input  wire logic                ref_clk_i,
   input  wire logic                reset_n_i,
   input  wire logic                instr_valid_i,
   input  wire lcb_pkg::lcb_instr_t instr_i,
   input  wire logic [7:0]          port_pins_i,
   output logic                     instr_ready_o,
   output logic                     done_o,
   output lcb_pkg::lcb_retire_t     retire_o,
   output logic [15:0]              pc_o,
   output logic [7:0]               acc_o,
   output logic [7:0]               status_o,
   output logic [7:0]               port_latch_o
);

   ////////////////////////////////////////////////////////////////////////
   // decode

   function automatic lcb_pkg::lcb_dec_t mk(input lcb_pkg::lcb_op_t op,
                                            input lcb_pkg::lcb_amode_t am,
                                            input logic [1:0] len,
                                            input logic [2:0] cyc);
      lcb_pkg::lcb_dec_t d;
      d.op     = op;
      d.amode  = am;
      d.bytes  = len;
      d.cycles = cyc;
      return d;
   endfunction

   function automatic lcb_pkg::lcb_dec_t decode(input logic [7:0] opc);
      lcb_pkg::lcb_dec_t d;
      logic [7:0]        rf;
      logic [7:0]        pf;
      d  = mk(lcb_pkg::OP_ILLEGAL, lcb_pkg::AM_NONE, lcb_pkg::LEN_1,
              lcb_pkg::CYC_1);
      rf = opc & lcb_pkg::REG_FORM_MASK;
      pf = opc & lcb_pkg::IND_FORM_MASK;
      if (rf == lcb_pkg::OPC_AND_A_REG)
         d = mk(lcb_pkg::OP_AND_A, lcb_pkg::AM_REG, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      else if (pf == lcb_pkg::OPC_AND_A_IND)
         d = mk(lcb_pkg::OP_AND_A, lcb_pkg::AM_IND, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_AND_A_DIR)
         d = mk(lcb_pkg::OP_AND_A, lcb_pkg::AM_DIR, lcb_pkg::LEN_2,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_AND_A_IMM)
         d = mk(lcb_pkg::OP_AND_A, lcb_pkg::AM_IMM, lcb_pkg::LEN_2,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_AND_DIR_A)
         d = mk(lcb_pkg::OP_AND_DIR, lcb_pkg::AM_DIR, lcb_pkg::LEN_2,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_AND_DIR_IM)
         d = mk(lcb_pkg::OP_AND_DIR, lcb_pkg::AM_DIR, lcb_pkg::LEN_3,
                lcb_pkg::CYC_2);
      else if (opc == lcb_pkg::OPC_AND_C_BIT)
         d = mk(lcb_pkg::OP_AND_C, lcb_pkg::AM_BIT, lcb_pkg::LEN_2,
                lcb_pkg::CYC_2);
      else if (opc == lcb_pkg::OPC_AND_C_NBIT)
         d = mk(lcb_pkg::OP_AND_CN, lcb_pkg::AM_BIT, lcb_pkg::LEN_2,
                lcb_pkg::CYC_2);
      else if (opc == lcb_pkg::OPC_CMP_A_DIR)
         d = mk(lcb_pkg::OP_CMP_JUMP, lcb_pkg::AM_DIR, lcb_pkg::LEN_3,
                lcb_pkg::CYC_2);
      else if (opc == lcb_pkg::OPC_CMP_A_IMM)
         d = mk(lcb_pkg::OP_CMP_JUMP, lcb_pkg::AM_IMM, lcb_pkg::LEN_3,
                lcb_pkg::CYC_2);
      else if (pf == lcb_pkg::OPC_CMP_IND)
         d = mk(lcb_pkg::OP_CMP_JUMP, lcb_pkg::AM_IND, lcb_pkg::LEN_3,
                lcb_pkg::CYC_2);
      else if (rf == lcb_pkg::OPC_CMP_REG)
         d = mk(lcb_pkg::OP_CMP_JUMP, lcb_pkg::AM_REG, lcb_pkg::LEN_3,
                lcb_pkg::CYC_2);
      else if (opc == lcb_pkg::OPC_CLEAR_A)
         d = mk(lcb_pkg::OP_CLEAR_A, lcb_pkg::AM_NONE, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_CLEAR_C)
         d = mk(lcb_pkg::OP_CLEAR_C, lcb_pkg::AM_NONE, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_CLEAR_BIT)
         d = mk(lcb_pkg::OP_CLEAR_BIT, lcb_pkg::AM_BIT, lcb_pkg::LEN_2,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_COMPL_A)
         d = mk(lcb_pkg::OP_COMPL_A, lcb_pkg::AM_NONE, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_COMPL_C)
         d = mk(lcb_pkg::OP_COMPL_C, lcb_pkg::AM_NONE, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_COMPL_BIT)
         d = mk(lcb_pkg::OP_COMPL_BIT, lcb_pkg::AM_BIT, lcb_pkg::LEN_2,
                lcb_pkg::CYC_1);
      else if (opc == lcb_pkg::OPC_DEC_ADJ)
         d = mk(lcb_pkg::OP_DEC_ADJ, lcb_pkg::AM_NONE, lcb_pkg::LEN_1,
                lcb_pkg::CYC_1);
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   lcb_pkg::lcb_state_t  state_q;
   lcb_pkg::lcb_instr_t  inst_q;
   lcb_pkg::lcb_dec_t    dec_q;
   lcb_pkg::lcb_dec_t    dec_in;
   lcb_pkg::lcb_retire_t retire_q;
   logic [7:0]           acc_q;
   logic [7:0]           status_q;
   logic [7:0]           port_q;
   logic [15:0]          pc_q;
   logic                 done_q;
   logic [7:0]           loc_q;
   logic                 loc_sfr_q;
   logic [1:0]           bank;
   logic [7:0]           idle_addr;
   logic [7:0]           rd_addr;
   logic [7:0]           ram_rd;
   logic                 accept;
   logic                 exec;

   assign bank   = status_q[lcb_pkg::FLAG_BANK_HI:lcb_pkg::FLAG_BANK_LO];
   assign dec_in = decode(instr_i.opcode);
   assign accept = instr_valid_i && (state_q == lcb_pkg::ST_IDLE);
   assign exec   = (state_q == lcb_pkg::ST_EXEC);

   // location of the operand as seen at acceptance; a pointer form first
   // fetches the pointer register and learns the real location later
   always_comb begin
      case (dec_in.amode)
         lcb_pkg::AM_REG: idle_addr = {3'h0, bank, instr_i.opcode[2:0]};
         lcb_pkg::AM_IND: idle_addr = {3'h0, bank, 2'h0, instr_i.opcode[0]};
         lcb_pkg::AM_DIR: idle_addr = instr_i.byte1;
         lcb_pkg::AM_BIT: begin
            if (instr_i.byte1[7]) begin
               idle_addr = {instr_i.byte1[7:3], 3'h0};
            end else begin
               idle_addr = lcb_pkg::BIT_AREA_BASE +
                           {4'h0, instr_i.byte1[6:3]};
            end
         end
         default: idle_addr = 8'h00;
      endcase
   end

   // read port: pointer value feeds the second read directly
   assign rd_addr = (state_q == lcb_pkg::ST_PTR) ? ram_rd : idle_addr;

   // sequencer: accept, optional pointer fetch, execute
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_q <= lcb_pkg::ST_IDLE;
      end else begin
         case (state_q)
            lcb_pkg::ST_IDLE: begin
               if (accept && dec_in.amode == lcb_pkg::AM_IND) begin
                  state_q <= lcb_pkg::ST_PTR;
               end else if (accept) begin
                  state_q <= lcb_pkg::ST_EXEC;
               end
            end
            lcb_pkg::ST_PTR:  state_q <= lcb_pkg::ST_EXEC;
            lcb_pkg::ST_EXEC: state_q <= lcb_pkg::ST_IDLE;
            default:          state_q <= lcb_pkg::ST_IDLE;
         endcase
      end
   end

   // instruction and operand location capture
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         inst_q    <= '0;
         dec_q     <= mk(lcb_pkg::OP_ILLEGAL, lcb_pkg::AM_NONE,
                         lcb_pkg::LEN_1, lcb_pkg::CYC_1);
         loc_q     <= 8'h00;
         loc_sfr_q <= 1'b0;
      end else if (accept) begin
         inst_q    <= instr_i;
         dec_q     <= dec_in;
         loc_q     <= idle_addr;
         loc_sfr_q <= idle_addr[7] && (dec_in.amode == lcb_pkg::AM_DIR ||
                                       dec_in.amode == lcb_pkg::AM_BIT);
      end else if (state_q == lcb_pkg::ST_PTR) begin
         loc_q     <= ram_rd; // indirect always lands in data memory
         loc_sfr_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // execute

   logic       rmw;
   logic [7:0] sfr_rd;
   logic [7:0] opnd;
   logic       bit_val;
   logic [7:0] lhs;
   logic [7:0] rhs;
   logic       acc_we;
   logic [7:0] acc_nx;
   logic       cy_we;
   logic       cy_nx;
   logic       wr_en;
   logic [7:0] wr_byte;
   logic       taken;
   logic [7:0] adj_acc;
   logic       adj_cy;
   logic [2:0] bit_idx;

   // read-modify-write forms see the port latch, plain reads see the pins
   assign rmw = dec_q.op == lcb_pkg::OP_AND_DIR ||
                dec_q.op == lcb_pkg::OP_CLEAR_BIT ||
                dec_q.op == lcb_pkg::OP_COMPL_BIT;
   assign bit_idx = inst_q.byte1[2:0];

   // special register read mux; parity always tracks the accumulator
   always_comb begin
      case (loc_q)
         lcb_pkg::SFR_PORT:   sfr_rd = rmw ? port_q : port_pins_i;
         lcb_pkg::SFR_STATUS: sfr_rd = {status_q[7:1], ^acc_q};
         lcb_pkg::SFR_ACC:    sfr_rd = acc_q;
         default:             sfr_rd = 8'h00;
      endcase
   end

   assign opnd = (dec_q.amode == lcb_pkg::AM_IMM) ? inst_q.byte1 :
                 loc_sfr_q ? sfr_rd : ram_rd;
   assign bit_val = opnd[bit_idx];

   lcb_dec_adj u_dec_adj (
      .acc_i       (acc_q),
      .carry_i     (status_q[lcb_pkg::FLAG_CARRY]),
      .aux_carry_i (status_q[lcb_pkg::FLAG_AUX_CARRY]),
      .acc_o       (adj_acc),
      .carry_o     (adj_cy)
   );

   // operation results; each op names what it may change, decimal adjust both accumulator and carry
   always_comb begin
      acc_we  = 1'b0;
      acc_nx  = acc_q;
      cy_we   = 1'b0;
      cy_nx   = status_q[lcb_pkg::FLAG_CARRY];
      wr_en   = 1'b0;
      wr_byte = opnd;
      taken   = 1'b0;
      lhs     = acc_q;
      rhs     = opnd;
      case (dec_q.op)
         lcb_pkg::OP_AND_A: begin
            acc_we = 1'b1;
            acc_nx = acc_q & opnd;
         end
         lcb_pkg::OP_AND_DIR: begin
            wr_en   = 1'b1;
            wr_byte = opnd & ((inst_q.opcode == lcb_pkg::OPC_AND_DIR_A) ?
                              acc_q : inst_q.byte2);
         end
         lcb_pkg::OP_AND_C: begin
            cy_we = !bit_val;
            cy_nx = 1'b0;
         end
         lcb_pkg::OP_AND_CN: begin
            cy_we = bit_val;
            cy_nx = 1'b0;
         end
         lcb_pkg::OP_CMP_JUMP: begin
            if (dec_q.amode == lcb_pkg::AM_REG ||
                dec_q.amode == lcb_pkg::AM_IND) begin
               lhs = opnd;
               rhs = inst_q.byte1;
            end
            cy_we = 1'b1;
            cy_nx = lhs < rhs;
            taken = lhs != rhs;
         end
         lcb_pkg::OP_CLEAR_A: begin
            acc_we = 1'b1;
            acc_nx = 8'h00;
         end
         lcb_pkg::OP_CLEAR_C: begin
            cy_we = 1'b1;
            cy_nx = 1'b0;
         end
         lcb_pkg::OP_CLEAR_BIT: begin
            wr_en            = 1'b1;
            wr_byte[bit_idx] = 1'b0;
         end
         lcb_pkg::OP_COMPL_A: begin
            acc_we = 1'b1;
            acc_nx = ~acc_q;
         end
         lcb_pkg::OP_COMPL_C: begin
            cy_we = 1'b1;
            cy_nx = !status_q[lcb_pkg::FLAG_CARRY];
         end
         lcb_pkg::OP_COMPL_BIT: begin
            wr_en            = 1'b1;
            wr_byte[bit_idx] = !bit_val;
         end
         lcb_pkg::OP_DEC_ADJ: begin
            acc_we = 1'b1;
            acc_nx = adj_acc;
            cy_we  = 1'b1;
            cy_nx  = adj_cy;
         end
         default: begin
            acc_we = 1'b0;
         end
      endcase
   end

   lcb_ram u_ram (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .rd_addr_i (rd_addr),
      .wr_en_i   (exec && wr_en && !loc_sfr_q),
      .wr_addr_i (loc_q),
      .wr_data_i (wr_byte),
      .rd_data_o (ram_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // architectural registers

   // accumulator: own ops, or a byte written at its special address
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         acc_q <= lcb_pkg::ACC_RST;
      end else if (exec && acc_we) begin
         acc_q <= acc_nx;
      end else if (exec && wr_en && loc_sfr_q &&
                   loc_q == lcb_pkg::SFR_ACC) begin
         acc_q <= wr_byte;
      end
   end

   // status word; overflow and aux carry only change by a byte write
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         status_q <= lcb_pkg::STATUS_RST;
      end else if (exec && cy_we) begin
         status_q[lcb_pkg::FLAG_CARRY] <= cy_nx;
      end else if (exec && wr_en && loc_sfr_q &&
                   loc_q == lcb_pkg::SFR_STATUS) begin
         status_q <= wr_byte;
      end
   end

   // port output latch, separate from the pins it drives
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         port_q <= lcb_pkg::PORT_RST;
      end else if (exec && wr_en && loc_sfr_q &&
                   loc_q == lcb_pkg::SFR_PORT) begin
         port_q <= wr_byte;
      end
   end

   // program counter: step past the instruction, then add displacement
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pc_q <= lcb_pkg::PC_RST;
      end else if (exec) begin
         pc_q <= pc_q + {14'h0, dec_q.bytes} +
                 (taken ? {{8{inst_q.byte2[7]}}, inst_q.byte2} :
                          16'h0000);
      end
   end

   // retire report, one pulse per instruction
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         done_q   <= 1'b0;
         retire_q <= '0;
      end else begin
         done_q <= exec;
         if (exec) begin
            retire_q.illegal <= dec_q.op == lcb_pkg::OP_ILLEGAL;
            retire_q.bytes   <= dec_q.bytes;
            retire_q.cycles  <= dec_q.cycles;
            retire_q.branch  <= taken;
         end
      end
   end

   assign instr_ready_o = (state_q == lcb_pkg::ST_IDLE);
   assign done_o        = done_q;
   assign retire_o      = retire_q;
   assign pc_o          = pc_q;
   assign acc_o         = acc_q;
   assign status_o      = {status_q[7:1], ^acc_q};
   assign port_latch_o  = port_q;

endmodule

// ### dv/lcb_core_monitor.sv
// port-level assertions for the datapath core
module lcb_core_monitor (
   input wire logic                 ref_clk_i,
   input wire logic                 reset_n_i,
   input wire logic                 instr_valid_i,
   input wire lcb_pkg::lcb_instr_t  instr_i,
   input wire logic                 instr_ready_o,
   input wire logic                 done_o,
   input wire lcb_pkg::lcb_retire_t retire_o,
   input wire logic [15:0]          pc_o,
   input wire logic [7:0]           acc_o,
   input wire logic [7:0]           status_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // a take is an offer seen while idle; results land two edges later, three for a pointer form
   wire        tk = instr_valid_i && instr_ready_o;
   wire [7:0]  op = instr_i.opcode;
   wire [7:0]  im = instr_i.byte1;
   wire [15:0] rel = {{8{instr_i.byte2[7]}}, instr_i.byte2};
   ////////////////////////////////////////////////////////////////
   property p_done; tk |-> ##[2:3] done_o; endproperty
   a_done: assert property (p_done) else $error("no retire");
   property p_and; tk && op == lcb_pkg::OPC_AND_A_IMM |-> ##2
      acc_o == ($past(acc_o, 2) & $past(im, 2))
      && status_o[7:1] == $past(status_o[7:1], 2); endproperty
   a_and: assert property (p_and) else $error("and imm");
   property p_clra; tk && op == lcb_pkg::OPC_CLEAR_A |-> ##2
      acc_o == 8'h00; endproperty
   a_clra: assert property (p_clra) else $error("clear acc");
   property p_cpla; tk && op == lcb_pkg::OPC_COMPL_A |-> ##2
      acc_o == ~$past(acc_o, 2); endproperty
   a_cpla: assert property (p_cpla) else $error("compl acc");
   property p_cmp; tk && op == lcb_pkg::OPC_CMP_A_IMM |-> ##2
      status_o[7] == ($past(acc_o, 2) < $past(im, 2))
      && acc_o == $past(acc_o, 2); endproperty
   a_cmp: assert property (p_cmp) else $error("cmp carry");
   property p_jmp; tk && op == lcb_pkg::OPC_CMP_A_IMM |-> ##2
      pc_o == $past(pc_o, 2) + 16'h0003 + (($past(acc_o, 2) != $past(im, 2))
      ? $past(rel, 2) : 16'h0000); endproperty
   a_jmp: assert property (p_jmp) else $error("cmp target");
   property p_da; tk && op == lcb_pkg::OPC_DEC_ADJ |-> ##2
      (!$past(status_o[7], 2) || status_o[7])
      && status_o[2] == $past(status_o[2], 2); endproperty
   a_da: assert property (p_da) else $error("adjust flags");
   property p_clrc; tk && op == lcb_pkg::OPC_CLEAR_C |-> ##2
      !status_o[7] && acc_o == $past(acc_o, 2); endproperty
   a_clrc: assert property (p_clrc) else $error("clear carry");
   c_da: cover property (tk && op == lcb_pkg::OPC_DEC_ADJ);
   c_br: cover property (done_o && retire_o.branch);
   c_ill: cover property (done_o && retire_o.illegal);
endmodule

bind lcb_core lcb_core_monitor i_lcb_core_monitor (.ref_clk_i, .reset_n_i,
   .instr_valid_i, .instr_i, .instr_ready_o, .done_o, .retire_o, .pc_o,
   .acc_o, .status_o);

// ### dv/tb_lcb_core.sv
// self-checking bench for the logic, compare and bcd datapath core
module tb_lcb_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk = 0;
   logic                 rst_n = 0;
   logic                 vld = 0;
   lcb_pkg::lcb_instr_t  ins = '0;
   logic [7:0]           pins = 8'h00;
   logic                 rdy, done, e_c;
   lcb_pkg::lcb_retire_t ret;
   logic [15:0]          pc, e_pc;
   logic [7:0]           acc, st, port, e_acc, e_port, d, rl;
   logic [31:0]          seed = 32'h7B1C;
   int                   n_errors = 0;
   int                   cmp_count = 0;
   lcb_core i_lcb_core (.ref_clk_i(clk), .reset_n_i(rst_n),
      .instr_valid_i(vld), .instr_i(ins), .port_pins_i(pins),
      .instr_ready_o(rdy), .done_o(done), .retire_o(ret), .pc_o(pc),
      .acc_o(acc), .status_o(st), .port_latch_o(port));
   // 250 MHz clock
   initial forever #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // decimal adjust; aux carry stays zero as nothing here can set it
   function automatic logic [8:0] fda(logic [7:0] a, logic c);
      logic [8:0] t;
      t = {1'b0, a} + ((a[3:0] > 4'h9) ? 9'h006 : 9'h000);
      c = c | t[8];
      t = {1'b0, t[7:0]} + ((t[7:4] > 4'h9 || c) ? 9'h060 : 9'h000);
      return {c | t[8], t[7:0]};
   endfunction
   task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s exp %0h got %0h", n, e, s);
      end
   endtask
   task automatic chk();
      cmp("state", {e_pc, e_acc, e_port}, {pc, acc, port});
      cmp("status", {e_c, 6'h00, ^e_acc}, st);
   endtask
   // offer at a falling edge, hold until taken, then wait for the retire
   task automatic run(logic [7:0] o, b1, b2, logic [15:0] len);
      int k;
      k = 0;
      while (rdy !== 1'b1 && k < 9) begin
         @(negedge clk);
         k++;
      end
      vld = 1;
      ins = {o, b1, b2};
      pins = 8'(rnd());
      @(negedge clk);
      vld = 0;
      cmp("ready", 0, rdy);
      k = 0;
      while (done !== 1'b1 && k < 9) begin
         @(negedge clk);
         k++;
      end
      if (k == 9) cmp("done", 1, 0);
      e_pc += len;
   endtask
   task automatic jmp(logic [7:0] o, a);
      run(o, d, rl, 16'h3);
      e_c = a < d;
      if (a != d) e_pc += {{8{rl[7]}}, rl};
      chk();
      cmp("branch", a != d, ret.branch);
   endtask
   task automatic results();
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // watchdog: 10000 cycles, about ten times the roughly 1000 cycles the run needs
   initial begin
      #40000;
      n_errors++;
      results();
   end
   initial begin
      {e_acc, e_c, e_pc, e_port} = {8'h00, 1'b0, 16'h0000, 8'hFF};
      repeat (2) @(negedge clk);
      rst_n = 1;
      chk();
      cmp("idle", 2'h2, {rdy, done});
      run(8'hA5, 0, 0, 16'h1);
      cmp("ill", {1'b1, lcb_pkg::LEN_1, lcb_pkg::CYC_1, 1'b0}, ret);
      // zero R0 and R1 so the register and pointer compares are known
      run(lcb_pkg::OPC_AND_DIR_IM, 8'h00, 8'h00, 16'h3);
      run(lcb_pkg::OPC_AND_DIR_IM, 8'h01, 8'h00, 16'h3);
      cmp("len3", {1'b0, lcb_pkg::LEN_3, lcb_pkg::CYC_2, 1'b0}, ret);
      for (int i = 0; i < 30; i++) begin
         d = 8'(rnd());
         rl = 8'(rnd());
         if (rl[3]) run(lcb_pkg::OPC_CLEAR_C, 0, 0, 16'h1);
         e_c &= !rl[3];
         run(lcb_pkg::OPC_CLEAR_A, 0, 0, 16'h1);
         e_acc = 8'h00;
         chk();
         run(lcb_pkg::OPC_COMPL_A, 0, 0, 16'h1);
         e_acc = 8'hFF;
         chk();
         run(lcb_pkg::OPC_AND_A_IMM, d, 0, 16'h2);
         e_acc = d;
         chk();
         if (rl[5]) run(lcb_pkg::OPC_COMPL_C, 0, 0, 16'h1);
         e_c ^= rl[5];
         run(lcb_pkg::OPC_DEC_ADJ, 0, 0, 16'h1);
         {e_c, e_acc} = fda(e_acc, e_c);
         chk();
         if (rl[0]) d = e_acc;
         jmp(lcb_pkg::OPC_CMP_A_IMM, e_acc);
         run(rl[1] ? lcb_pkg::OPC_AND_C_BIT : lcb_pkg::OPC_AND_C_NBIT,
             {5'h1C, rl[4:2]}, 0, 16'h2);
         e_c &= e_acc[rl[4:2]] ^ !rl[1];
         chk();
         cmp("len2", {1'b0, lcb_pkg::LEN_2, lcb_pkg::CYC_2, 1'b0}, ret);
         run(lcb_pkg::OPC_AND_DIR_IM, 8'h90, d, 16'h3);
         e_port &= d;
         chk();
         run(lcb_pkg::OPC_COMPL_BIT, {5'h12, rl[7:5]}, 0, 16'h2);
         e_port[rl[7:5]] ^= 1'b1;
         chk();
         run(lcb_pkg::OPC_CLEAR_BIT, {5'h12, rl[4:2]}, 0, 16'h2);
         e_port[rl[4:2]] = 1'b0;
         chk();
         run(lcb_pkg::OPC_AND_DIR_A, 8'h90, 0, 16'h2);
         e_port &= e_acc;
         chk();
         run(lcb_pkg::OPC_AND_A_DIR, 8'h90, 0, 16'h2);
         e_acc &= pins;
         chk();
         if (rl[6]) d = 8'h00;
         jmp(lcb_pkg::OPC_CMP_REG, 8'h00);
         jmp(lcb_pkg::OPC_CMP_IND | 8'h01, 8'h00);
         // direct byte 00 holds zero, so d is both the direct address and the expected operand
         d = 8'h00;
         jmp(lcb_pkg::OPC_CMP_A_DIR, e_acc);
         run(rl[7] ? lcb_pkg::OPC_AND_A_IND | 8'h01 : lcb_pkg::OPC_AND_A_REG,
             0, 0, 16'h1);
         e_acc = 8'h00;
         chk();
      end
      results();
   end
endmodule
